/* File: rtl/sbcf_bank_fsm.sv */
`timescale 1ns/100ps
module sbcf_bank_fsm
  import sbcf_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int BURST_LENGTH = BURST_LENGTH_DEFAULT,
  parameter int READ_LATENCY = READ_LATENCY_DEFAULT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic chipSelect_n,
  input wire logic rowStrobe_n,
  input wire logic columnStrobe_n,
  input wire logic writeEnable_n,
  input wire logic [$clog2(BANKS)-1:0] bankAddress,
  input wire logic [AUTOPRECHARGE_BIT_POS:0] address,
  output logic [BANKS*4-1:0] bankState,
  output logic [BANKS-1:0] illegalCommand,
  output logic readDataValid,
  output logic allBanksIdle
);
  // ==========================================================
  // State
  typedef struct packed {
    sbcf_state_e [BANKS-1:0] state;
    logic [BANKS-1:0][TIMER_WIDTH-1:0] timer;
    logic [BANKS-1:0] autoPrecharge;
    logic [BANKS-1:0] illegal;
    logic [BANKS*4-1:0] stateOut;
    logic [7:0] readPipe;
    logic readValid;
    logic idleAll;
    logic cePrev;
  } sbcf_regs_s;

  localparam logic [TIMER_WIDTH-1:0] BURST_CYC = TIMER_WIDTH'(BURST_LENGTH);
  localparam logic [TIMER_WIDTH-1:0] RP_CYC = TIMER_WIDTH'(PRECHARGE_PERIOD_CYC);
  localparam logic [TIMER_WIDTH-1:0] RCD_CYC = TIMER_WIDTH'(ACTIVATE_TO_COLUMN_DELAY_CYC);
  localparam logic [TIMER_WIDTH-1:0] RC_CYC = TIMER_WIDTH'(ROW_CYCLE_CYC);
  localparam logic [TIMER_WIDTH-1:0] WR_CYC = TIMER_WIDTH'(WRITE_RECOVERY_CYC);
  localparam logic [TIMER_WIDTH-1:0] MRS_CYC = TIMER_WIDTH'(MODE_ACCESS_CYC);
  localparam logic [TIMER_WIDTH-1:0] ONE = 8'h01;

  sbcf_regs_s r;
  sbcf_regs_s next_r;
  sbcf_cmd_e cmd;
  logic ceOk;
  logic readIssued;
  logic writeIssued;
  logic stopRead;

  // ==========================================================
  // Command decode
  always_comb begin
    cmd = SBCF_CMD_NOP;
    if (!chipSelect_n) begin
      case ({rowStrobe_n, columnStrobe_n, writeEnable_n})
        3'h7: cmd = SBCF_CMD_NOP;
        3'h6: cmd = SBCF_CMD_STOP;
        3'h5: cmd = SBCF_CMD_READ;
        3'h4: cmd = SBCF_CMD_WRITE;
        3'h3: cmd = SBCF_CMD_ACTIVATE;
        3'h2: cmd = SBCF_CMD_PRECHARGE;
        3'h1: cmd = SBCF_CMD_REFRESH;
        3'h0: cmd = SBCF_CMD_MODE;
        default: cmd = SBCF_CMD_NOP;
      endcase
    end
  end

  // Previous and current clock enable must both be high.
  assign ceOk = clockEnable && r.cePrev;

  // ==========================================================
  // Per-bank next state
  always_comb begin
    next_r = r;
    next_r.cePrev = clockEnable;
    readIssued = 1'b0;
    writeIssued = 1'b0;
    stopRead = 1'b0;
    for (int b = 0; b < BANKS; b++) begin
      logic sel;
      logic [TIMER_WIDTH-1:0] t;
      logic done;
      sel = ceOk && (bankAddress == b[$clog2(BANKS)-1:0]);
      t = r.timer[b];
      done = (t <= ONE);
      next_r.illegal[b] = 1'b0;
      if (ceOk && t != 8'h00) begin
        next_r.timer[b] = t - ONE;
      end
      // A refresh or mode access addresses every bank, not just one.
      if (ceOk && (cmd == SBCF_CMD_REFRESH || cmd == SBCF_CMD_MODE)) begin
        sel = 1'b1;
      end
      if (ceOk) begin
        case (r.state[b])
          SBCF_IDLE: begin
            if (sel && cmd == SBCF_CMD_ACTIVATE) begin
              next_r.state[b] = SBCF_ACTIVATING;
              next_r.timer[b] = RCD_CYC;
            end else if (cmd == SBCF_CMD_REFRESH) begin
              next_r.state[b] = SBCF_REFRESHING;
              next_r.timer[b] = RC_CYC;
            end else if (cmd == SBCF_CMD_MODE) begin
              next_r.state[b] = SBCF_MODE_ACCESS;
              next_r.timer[b] = MRS_CYC;
            end else if (sel && (cmd == SBCF_CMD_STOP || cmd == SBCF_CMD_READ
                                 || cmd == SBCF_CMD_WRITE)) begin
              next_r.illegal[b] = 1'b1;
            end
          end
          SBCF_ACTIVATING: begin
            if (sel && cmd != SBCF_CMD_NOP) begin
              next_r.illegal[b] = 1'b1;
            end
            if (done) begin
              next_r.state[b] = SBCF_ROW_ACTIVE;
            end
          end
          SBCF_ROW_ACTIVE, SBCF_READ, SBCF_WRITE: begin
            if (sel && (cmd == SBCF_CMD_READ || cmd == SBCF_CMD_WRITE)) begin
              // Interrupting access restarts the burst at the new column.
              next_r.autoPrecharge[b] = address[AUTOPRECHARGE_BIT_POS];
              next_r.timer[b] = BURST_CYC;
              readIssued = (cmd == SBCF_CMD_READ);
              writeIssued = (cmd == SBCF_CMD_WRITE);
              if (address[AUTOPRECHARGE_BIT_POS]) begin
                next_r.state[b] = (cmd == SBCF_CMD_READ) ? SBCF_READ_AP : SBCF_WRITE_AP;
              end else begin
                next_r.state[b] = (cmd == SBCF_CMD_READ) ? SBCF_READ : SBCF_WRITE;
              end
            end else if (sel && cmd == SBCF_CMD_PRECHARGE) begin
              if (r.state[b] == SBCF_WRITE) begin
                next_r.state[b] = SBCF_RECOVER;
                next_r.timer[b] = WR_CYC;
              end else begin
                next_r.state[b] = SBCF_PRECHARGING;
                next_r.timer[b] = RP_CYC;
                stopRead = stopRead || (r.state[b] == SBCF_READ);
              end
            end else if (sel && cmd == SBCF_CMD_STOP && r.state[b] != SBCF_ROW_ACTIVE) begin
              next_r.state[b] = SBCF_ROW_ACTIVE;
              next_r.timer[b] = 8'h00;
              stopRead = stopRead || (r.state[b] == SBCF_READ);
            end else if (sel && (cmd == SBCF_CMD_ACTIVATE || cmd == SBCF_CMD_REFRESH
                                 || cmd == SBCF_CMD_MODE)) begin
              next_r.illegal[b] = 1'b1;
            end else if (r.state[b] != SBCF_ROW_ACTIVE && done) begin
              next_r.state[b] = SBCF_ROW_ACTIVE;
            end
          end
          SBCF_READ_AP, SBCF_WRITE_AP: begin
            if (sel && cmd != SBCF_CMD_NOP) begin
              next_r.illegal[b] = 1'b1;
            end
            if (done) begin
              // Writes still need recovery before the row closes.
              if (r.state[b] == SBCF_WRITE_AP) begin
                next_r.state[b] = SBCF_RECOVER;
                next_r.timer[b] = WR_CYC;
              end else begin
                next_r.state[b] = SBCF_PRECHARGING;
                next_r.timer[b] = RP_CYC;
              end
            end
          end
          SBCF_RECOVER: begin
            if (sel && cmd != SBCF_CMD_NOP && cmd != SBCF_CMD_PRECHARGE) begin
              next_r.illegal[b] = 1'b1;
            end
            if (done) begin
              next_r.state[b] = SBCF_PRECHARGING;
              next_r.timer[b] = RP_CYC;
            end
          end
          SBCF_PRECHARGING: begin
            if (sel && cmd != SBCF_CMD_NOP && cmd != SBCF_CMD_PRECHARGE) begin
              next_r.illegal[b] = 1'b1;
            end
            if (done) begin
              next_r.state[b] = SBCF_IDLE;
            end
          end
          SBCF_REFRESHING: begin
            if (sel && cmd != SBCF_CMD_NOP) begin
              next_r.illegal[b] = 1'b1;
            end
            if (done) begin
              next_r.state[b] = SBCF_IDLE;
            end
          end
          SBCF_MODE_ACCESS: begin
            if (sel && cmd != SBCF_CMD_NOP) begin
              next_r.illegal[b] = 1'b1;
            end
            if (done) begin
              next_r.state[b] = SBCF_IDLE;
            end
          end
          default: begin
            next_r.state[b] = SBCF_IDLE;
          end
        endcase
      end
      next_r.stateOut[b*4 +: 4] = next_r.state[b];
    end
    // Read data pipe: bit 0 is the word of the coming cycle.
    // A stop or precharge keeps only the words already launched from the array.
    next_r.readPipe = r.readPipe >> 1;
    if (readIssued) begin
      next_r.readPipe = (8'hff >> (8 - BURST_LENGTH)) << (READ_LATENCY - 1);
    end else if (writeIssued) begin
      next_r.readPipe = 8'h00;
    end else if (stopRead) begin
      next_r.readPipe = (r.readPipe >> 1) & ~(8'hff << (READ_LATENCY - 2));
    end
    next_r.readValid = r.readPipe[0];
    next_r.idleAll = 1'b1;
    for (int b = 0; b < BANKS; b++) begin
      if (next_r.state[b] != SBCF_IDLE) begin
        next_r.idleAll = 1'b0;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
      r.idleAll <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign bankState = r.stateOut;
  assign illegalCommand = r.illegal;
  assign readDataValid = r.readValid;
  assign allBanksIdle = r.idleAll;
endmodule

/* File: rtl/sbcf_pkg.sv */
package sbcf_pkg;
  // Timing figures in ns, as printed or chosen, and cycle counts at 200 MHz.
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
  localparam int ROW_CYCLE_NS = 80;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int PRECHARGE_PERIOD_CYC =
    (PRECHARGE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ACTIVATE_TO_COLUMN_DELAY_CYC =
    (ACTIVATE_TO_COLUMN_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int WRITE_RECOVERY_CYC =
    (WRITE_RECOVERY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int MODE_ACCESS_CYC = 2;
  localparam int BURST_LENGTH_DEFAULT = 4;
  localparam int READ_LATENCY_DEFAULT = 2;
  localparam int TIMER_WIDTH = 8;
  localparam int AUTOPRECHARGE_BIT_POS = 10;

  typedef enum logic [2:0] {
    SBCF_CMD_NOP,
    SBCF_CMD_STOP,
    SBCF_CMD_READ,
    SBCF_CMD_WRITE,
    SBCF_CMD_ACTIVATE,
    SBCF_CMD_PRECHARGE,
    SBCF_CMD_REFRESH,
    SBCF_CMD_MODE
  } sbcf_cmd_e;

  typedef enum logic [3:0] {
    SBCF_IDLE,
    SBCF_ACTIVATING,
    SBCF_ROW_ACTIVE,
    SBCF_READ,
    SBCF_WRITE,
    SBCF_READ_AP,
    SBCF_WRITE_AP,
    SBCF_RECOVER,
    SBCF_PRECHARGING,
    SBCF_REFRESHING,
    SBCF_MODE_ACCESS
  } sbcf_state_e;
endpackage

/* File: verif/sbcf_bank_fsm_checker.sv */
`timescale 1ns/100ps
// ==========
// Port checker for bank 0.
module sbcf_bank_fsm_checker
  import sbcf_pkg::*;
#(
  parameter int BANKS = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic chipSelect_n,
  input wire logic rowStrobe_n,
  input wire logic columnStrobe_n,
  input wire logic writeEnable_n,
  input wire logic [$clog2(BANKS)-1:0] bankAddress,
  input wire logic [AUTOPRECHARGE_BIT_POS:0] address,
  input wire logic [BANKS*4-1:0] bankState,
  input wire logic [BANKS-1:0] illegalCommand,
  input wire logic readDataValid,
  input wire logic allBanksIdle
);
  logic prevCke;
  logic [3:0] s0;
  logic live;
  logic b0;
  logic [2:0] op;
  always_ff @(posedge clock) prevCke <= rst ? 1'h0 : clockEnable;
  assign s0 = bankState[3:0];
  assign live = clockEnable && prevCke && !chipSelect_n;
  assign b0 = bankAddress == '0;
  assign op = {rowStrobe_n, columnStrobe_n, writeEnable_n};
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence actToRow;
    s0 == SBCF_ACTIVATING ##[3:4] s0 == SBCF_ROW_ACTIVE;
  endsequence
  sequence refToIdle;
    s0 == SBCF_REFRESHING ##[15:16] s0 == SBCF_IDLE;
  endsequence
  reset_idle_a: assert property (disable iff (1'h0) rst |=> bankState == '0 && allBanksIdle)
    else $error("state not idle after reset");
  activate_delay_a: assert property (live && b0 && op == 3'h3 && s0 == SBCF_IDLE |=> actToRow)
    else $error("activate delay wrong");
  activating_illegal_a: assert property (live && b0 && s0 == SBCF_ACTIVATING && op inside {3'h4, 3'h5}
    |=> illegalCommand[0]) else $error("illegal column command not flagged");
  other_bank_a: assert property (live && bankAddress == 1 && op == 3'h3 && s0 == SBCF_ACTIVATING
    |=> !illegalCommand[0]) else $error("other bank command flagged here");
  stop_read_a: assert property (live && b0 && op == 3'h6 && s0 == SBCF_READ
    |=> s0 == SBCF_ROW_ACTIVE) else $error("burst stop left row inactive");
  read_interrupt_a: assert property (live && b0 && s0 == SBCF_READ && op == 3'h4 && address[10]
    |=> s0 == SBCF_WRITE_AP) else $error("interrupting write not taken");
  read_precharge_a: assert property (live && b0 && s0 == SBCF_READ && op == 3'h2
    |=> s0 == SBCF_PRECHARGING) else $error("precharge in read not taken");
  write_precharge_a: assert property (live && b0 && s0 == SBCF_WRITE && op == 3'h2
    |=> s0 inside {SBCF_RECOVER, SBCF_PRECHARGING}) else $error("precharge in write not taken");
  ap_close_a: assert property (s0 == SBCF_READ_AP ##1 s0 != SBCF_READ_AP |-> s0 == SBCF_PRECHARGING)
    else $error("auto precharge skipped");
  refresh_idle_a: assert property (live && op == 3'h1 && allBanksIdle |=> refToIdle)
    else $error("refresh timing wrong");
  mode_idle_a: assert property (live && op == 3'h0 && allBanksIdle
    |=> s0 == SBCF_MODE_ACCESS ##[1:2] s0 == SBCF_IDLE) else $error("mode access timing wrong");
  cke_hold_a: assert property (!(clockEnable && prevCke) && s0 == SBCF_IDLE |=> s0 == SBCF_IDLE)
    else $error("command taken without clock enable");
endmodule
bind sbcf_bank_fsm sbcf_bank_fsm_checker #(.BANKS(BANKS)) u_chk (.clock(clock), .rst(rst),
  .clockEnable(clockEnable), .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n),
  .columnStrobe_n(columnStrobe_n), .writeEnable_n(writeEnable_n), .bankAddress(bankAddress),
  .address(address), .bankState(bankState), .illegalCommand(illegalCommand),
  .readDataValid(readDataValid), .allBanksIdle(allBanksIdle));

/* File: verif/sbcf_ctrl_model.sv */
`timescale 1ns/100ps
// ==========
// Command driver standing in for the memory controller.
module sbcf_ctrl_model
  import sbcf_pkg::*;
(
  input wire sbcf_cmd_e cmd,
  input wire logic [1:0] bank,
  input wire logic autoPrecharge,
  output logic chipSelect_n,
  output logic rowStrobe_n,
  output logic columnStrobe_n,
  output logic writeEnable_n,
  output logic [1:0] bankAddress,
  output logic [10:0] address
);
  // The enum order mirrors the strobe code, so one subtraction encodes it.
  // Sequencing in the bench keeps spacing and all-idle demands.
  // A no-operation aimed at bank 2 or 3 goes out as a deselect, so both idle forms are used.
  assign chipSelect_n = (cmd == SBCF_CMD_NOP) && bank[1];
  assign {rowStrobe_n, columnStrobe_n, writeEnable_n} = 3'h7 - 3'(cmd);
  assign bankAddress = bank;
  assign address = {autoPrecharge, 10'h155};
endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
// ==========
// Bench: table of command rows, then hand cases.
module tb import sbcf_pkg::*;;
  typedef struct {sbcf_cmd_e c; logic [1:0] b; logic a; int n; logic [3:0] e;} sbcf_row_s;
  logic clock, rst, clockEnable, autoPrecharge, readDataValid, allBanksIdle;
  logic chipSelect_n, rowStrobe_n, columnStrobe_n, writeEnable_n;
  sbcf_cmd_e cmd;
  logic [1:0] bank, bankAddress;
  logic [10:0] address;
  logic [15:0] bankState;
  logic [3:0] illegalCommand;
  int num_errors = 0;
  int checks = 0;
  sbcf_row_s rows [28] = '{
    '{SBCF_CMD_ACTIVATE, 0, 0, 0, 1}, '{SBCF_CMD_ACTIVATE, 1, 0, 0, 1}, '{SBCF_CMD_NOP, 0, 0, 5, 2},
    '{SBCF_CMD_READ, 0, 0, 0, 3}, '{SBCF_CMD_STOP, 0, 0, 0, 2}, '{SBCF_CMD_READ, 0, 0, 0, 3},
    '{SBCF_CMD_WRITE, 0, 1, 0, 6}, '{SBCF_CMD_NOP, 2, 0, 20, 0}, '{SBCF_CMD_ACTIVATE, 0, 0, 5, 2},
    '{SBCF_CMD_WRITE, 0, 0, 0, 4}, '{SBCF_CMD_READ, 0, 0, 0, 3}, '{SBCF_CMD_PRECHARGE, 0, 0, 0, 8},
    '{SBCF_CMD_PRECHARGE, 0, 0, 0, 8}, '{SBCF_CMD_NOP, 0, 0, 5, 0}, '{SBCF_CMD_ACTIVATE, 0, 0, 5, 2},
    '{SBCF_CMD_WRITE, 0, 0, 0, 4}, '{SBCF_CMD_PRECHARGE, 0, 0, 12, 0},
    '{SBCF_CMD_ACTIVATE, 0, 0, 5, 2}, '{SBCF_CMD_READ, 0, 1, 0, 5}, '{SBCF_CMD_NOP, 0, 0, 15, 0},
    '{SBCF_CMD_ACTIVATE, 0, 0, 5, 2}, '{SBCF_CMD_WRITE, 0, 0, 15, 2},
    '{SBCF_CMD_PRECHARGE, 0, 0, 6, 0}, '{SBCF_CMD_PRECHARGE, 1, 0, 6, 0},
    '{SBCF_CMD_MODE, 0, 0, 0, 10}, '{SBCF_CMD_NOP, 0, 0, 3, 0},
    '{SBCF_CMD_REFRESH, 0, 0, 0, 9}, '{SBCF_CMD_NOP, 0, 0, 20, 0}};
  sbcf_ctrl_model i_ctrl (.cmd(cmd), .bank(bank), .autoPrecharge(autoPrecharge),
    .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n), .columnStrobe_n(columnStrobe_n),
    .writeEnable_n(writeEnable_n), .bankAddress(bankAddress), .address(address));
  sbcf_bank_fsm i_dut (.clock(clock), .rst(rst), .clockEnable(clockEnable),
    .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n), .columnStrobe_n(columnStrobe_n),
    .writeEnable_n(writeEnable_n), .bankAddress(bankAddress), .address(address),
    .bankState(bankState), .illegalCommand(illegalCommand), .readDataValid(readDataValid),
    .allBanksIdle(allBanksIdle));
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Each command is followed by no-operations so that timers run undisturbed.
  task automatic issue(input sbcf_cmd_e c, input logic [1:0] b, input logic a, input int n);
    @(posedge clock);
    cmd <= c;
    bank <= b;
    autoPrecharge <= a;
    @(posedge clock);
    cmd <= SBCF_CMD_NOP;
    repeat (n) @(posedge clock);
    #1;
  endtask
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (2000) @(posedge clock);
    num_errors++;
    summarize();
  end
  initial begin
    rst = 1'h1;
    clockEnable = 1'h1;
    cmd = SBCF_CMD_NOP;
    {bank, autoPrecharge} = 3'h0;
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    repeat (2) @(posedge clock);
    #1;
    check({allBanksIdle, bankState}, 17'h10000);
    $display("reset test done");
    foreach (rows[i]) begin
      issue(rows[i].c, rows[i].b, rows[i].a, rows[i].n);
      check(bankState[3:0], rows[i].e);
    end
    $display("table test done");
    issue(SBCF_CMD_ACTIVATE, 2'h0, 1'h0, 0);
    issue(SBCF_CMD_READ, 2'h0, 1'h0, 0);
    check(illegalCommand, 4'h1);
    issue(SBCF_CMD_NOP, 2'h0, 1'h0, 0);
    issue(SBCF_CMD_PRECHARGE, 2'h0, 1'h0, 8);
    check(bankState[3:0], 4'h0);
    @(posedge clock);
    clockEnable <= 1'h0;
    issue(SBCF_CMD_ACTIVATE, 2'h0, 1'h0, 1);
    check(bankState[3:0], 4'h0);
    @(posedge clock);
    clockEnable <= 1'h1;
    issue(SBCF_CMD_ACTIVATE, 2'h2, 1'h0, 4);
    issue(SBCF_CMD_READ, 2'h2, 1'h0, 2);
    check(readDataValid, 1'h1);
    issue(SBCF_CMD_STOP, 2'h2, 1'h0, 1);
    check({readDataValid, bankState[11:8]}, 5'h02);
    @(posedge clock);
    rst <= 1'h1;
    @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    #1;
    check({allBanksIdle, bankState}, 17'h10000);
    $display("hand tests done");
    summarize();
  end
endmodule
